// File: src/pdr_ctrl.sv
// Module: restart sequencer after momentary supply dip
// Contract
// R1: Link undervoltage while running is a failure
// R2: Mode 0 stops, alarms, never restarts
// R3: Mode 1 stops, alarms only on recovery
// R4: Mode 4 saves frequency, restarts from it
// R5: Current limit lowers frequency, then ramps up
// R6: Configurer enables overcurrent limiter in mode 4
// R7: Mode 5 restarts at starting frequency
// R8: Restart held off at least half second
// R9: Wait two seconds for run, later start low
// R10: Run command returns within two seconds
// R11: Coast stop cancels restart wait
// R12: Alarm latched until alarm reset
`timescale 1ns/10ps
module pdr_ctrl #(
   parameter int HOLD_CYCLES = pdr_pkg::HOLD_CYC, // Restart hold-off
   parameter int WAIT_CYCLES = pdr_pkg::WAIT_CYC, // Run wait window
   parameter int STEP_DIV = 1000                 // Ramp step clocks
) (
   input wire logic clk_i,            // Clock 50 MHz
   input wire logic rst_i,            // Sync reset
   input wire logic [3:0] addr_i,     // Register address
   input wire logic [31:0] wdata_i,   // Write data
   input wire logic wr_i,             // Write strobe
   input wire logic rd_i,             // Read strobe
   output logic [31:0] rdata_o,       // Read data
   input wire logic [15:0] vdc_i,     // DC link voltage sample
   input wire logic run_cmd_i,        // Run command
   input wire logic coast_stop_command_i, // Coast-to-stop
   input wire logic over_current_i,   // Output current over limit
   output logic gate_en_o,            // Output stage enable
   output logic [15:0] freq_o,        // Output frequency
   output logic alarm_o,              // Undervoltage alarm
   output logic irq_o                 // Interrupt level
);
   pdr_pkg::pdr_state_t state;        // Sequencer state
   logic [2:0] restart_mode_select;   // Restart mode
   logic overcurrent_limit_enable;    // Limiter enable
   logic [15:0] vthr;                 // Undervoltage threshold
   logic [15:0] start_frequency_setting; // Starting frequency
   logic [15:0] fcmd;                 // Frequency command
   logic [15:0] fsave;                // Saved frequency
   logic [31:0] tmr;                  // Hold/wait timer
   logic [pdr_pkg::IRQ_W-1:0] irq_st; // Sticky events
   logic [pdr_pkg::IRQ_W-1:0] irq_mask; // Event mask
   logic [pdr_pkg::IRQ_W-1:0] ev;     // Events this cycle
   logic alarm;                       // Latched alarm
   logic low_v;                       // Supply below threshold
   logic hold_done;                   // Hold-off elapsed
   logic wr_ctrl;                     // Control written
   logic alarm_clr;                   // Alarm reset strobe
   logic go_saved;                    // Restart from saved
   logic go_start;                    // Restart at starting freq
   logic resume_saved; // Ramp aims at saved frequency
   logic bad_mode; // Mode without a restart action
   pdr_ramp_if rif ();                // Ramp controls

   // Plain level compare; the link sample is taken as already filtered
   assign low_v = vdc_i < vthr;
   assign bad_mode = restart_mode_select != pdr_pkg::MODE_SAVED_F && restart_mode_select != pdr_pkg::MODE_START_F;
   assign hold_done = tmr >= 32'(HOLD_CYCLES);
   assign wr_ctrl = wr_i && addr_i == pdr_pkg::ADDR_CTRL;
   assign alarm_clr = wr_ctrl && wdata_i[pdr_pkg::CTRL_ARST_BIT];

   // Ramp generator
   pdr_ramp #(
      .STEP_DIV(STEP_DIV)
   ) u_ramp (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .r(rif.rmp)
   );

   // Configuration registers
   // A write lands at the edge that samples the strobe
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         restart_mode_select <= pdr_pkg::MODE_TRIP_NOW;
         overcurrent_limit_enable <= 1'b0;
         vthr <= pdr_pkg::VTHR_RST;
         start_frequency_setting <= pdr_pkg::FSTART_RST;
         fcmd <= 16'h0000;
         irq_mask <= '0;
      end
      else if (wr_i)
      begin
         unique case (addr_i)
            pdr_pkg::ADDR_CTRL:
            begin
               restart_mode_select <= wdata_i[pdr_pkg::CTRL_MODE_LSB +: 3];
               overcurrent_limit_enable <= wdata_i[pdr_pkg::CTRL_OCL_BIT];
            end
            pdr_pkg::ADDR_VTHR: vthr <= wdata_i[15:0];
            pdr_pkg::ADDR_FSTART: start_frequency_setting <= wdata_i[15:0];
            pdr_pkg::ADDR_FCMD: fcmd <= wdata_i[15:0];
            pdr_pkg::ADDR_MASK: irq_mask <= wdata_i[pdr_pkg::IRQ_W-1:0];
            default: ; // Other addresses store nothing
         endcase
      end
   end

   // Restart decision after recovery and hold-off
   // Timer runs from detection, so the window is hold-off plus wait
   // A late run command falls back to the starting frequency
   always_comb
   begin
      go_saved = 1'b0;
      go_start = 1'b0;
      if (state == pdr_pkg::ST_WAIT && run_cmd_i && !low_v && hold_done) // R8
      begin
         if (tmr < 32'(HOLD_CYCLES + WAIT_CYCLES) && restart_mode_select == pdr_pkg::MODE_SAVED_F)
            go_saved = 1'b1; // R4 R9
         else
            go_start = 1'b1; // R7 R9
      end
   end

   // Sequencer state
   // Low link in RUN outranks a dropped run command
   // Alarm state is left only once the latch is cleared
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         state <= pdr_pkg::ST_IDLE;
      else
      begin
         unique case (state)
            pdr_pkg::ST_IDLE:
               if (alarm)
                  state <= pdr_pkg::ST_ALARM;
               else if (run_cmd_i && !coast_stop_command_i && !low_v)
                  state <= pdr_pkg::ST_RUN;
            pdr_pkg::ST_RUN:
               if (low_v) // R1
               begin
                  if (restart_mode_select == pdr_pkg::MODE_TRIP_NOW)
                     state <= pdr_pkg::ST_ALARM; // R2
                  else if (restart_mode_select == pdr_pkg::MODE_TRIP_REC)
                     state <= pdr_pkg::ST_DOWN; // R3
                  else
                     state <= pdr_pkg::ST_HOLD;
               end
               else if (!run_cmd_i || coast_stop_command_i)
                  state <= pdr_pkg::ST_IDLE;
            pdr_pkg::ST_DOWN:
               if (!low_v)
                  state <= pdr_pkg::ST_ALARM; // R3
            pdr_pkg::ST_HOLD:
               if (coast_stop_command_i)
                  state <= pdr_pkg::ST_IDLE; // R11
               else if (bad_mode)
                  state <= pdr_pkg::ST_ALARM; // Unsupported mode trips and alarms
               else if (!low_v)
                  state <= pdr_pkg::ST_WAIT;
            pdr_pkg::ST_WAIT:
               if (coast_stop_command_i)
                  state <= pdr_pkg::ST_IDLE; // R11
               else if (low_v)
                  state <= pdr_pkg::ST_HOLD;
               else if (go_saved || go_start)
                  state <= pdr_pkg::ST_RUN;
            pdr_pkg::ST_ALARM:
               if (!alarm)
                  state <= pdr_pkg::ST_IDLE; // R12
            default: state <= pdr_pkg::ST_IDLE;
         endcase
      end
   end

   // Timer counts from failure detection; saturates
   // Counting from detection keeps short dips under the full hold-off
   always_ff @(posedge clk_i)
   begin
      if (rst_i || state == pdr_pkg::ST_RUN || state == pdr_pkg::ST_IDLE)
         tmr <= '0;
      else if (tmr != 32'hFFFFFFFF)
         tmr <= tmr + 32'h1; // R8
   end

   // Saved frequency at failure
   // Taken from the ramp, one cycle ahead of the output flop
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         fsave <= 16'h0000;
      else if (state == pdr_pkg::ST_RUN && low_v)
         fsave <= rif.freq; // R4
   end

   // Alarm latch; raising wins over clearing
   // Held through recovery until software writes the reset bit
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         alarm <= 1'b0;
      else if (ev[pdr_pkg::IRQ_ALARM])
         alarm <= 1'b1; // R2 R3
      else if (alarm_clr)
         alarm <= 1'b0; // R12
   end

   // Event pulses
   // One-cycle pulses that feed the sticky status bits
   always_comb
   begin
      ev = '0;
      ev[pdr_pkg::IRQ_FAIL] = state == pdr_pkg::ST_RUN && low_v;
      ev[pdr_pkg::IRQ_REC] = (state == pdr_pkg::ST_HOLD || state == pdr_pkg::ST_DOWN) && !low_v;
      ev[pdr_pkg::IRQ_ALARM] = (state == pdr_pkg::ST_RUN && low_v && restart_mode_select == pdr_pkg::MODE_TRIP_NOW)
                               || (state == pdr_pkg::ST_DOWN && !low_v)
                               || (state == pdr_pkg::ST_HOLD && bad_mode && !coast_stop_command_i);
      ev[pdr_pkg::IRQ_RESTART] = go_saved || go_start;
   end

   // Sticky interrupt status, per bit; set wins over write-one clear
   // An event in the clearing cycle stays visible to software
   genvar gi;
   generate
      for (gi = 0; gi < pdr_pkg::IRQ_W; gi++)
      begin : g_irq
         always_ff @(posedge clk_i)
         begin
            if (rst_i)
               irq_st[gi] <= 1'b0;
            else if (ev[gi])
               irq_st[gi] <= 1'b1;
            else if (wr_i && addr_i == pdr_pkg::ADDR_IRQ && wdata_i[gi])
               irq_st[gi] <= 1'b0;
         end
      end
   endgenerate

   // Ramp control
   // Load on every start; target follows command or saved value
   always_comb
   begin
      rif.load = go_saved || go_start || (state == pdr_pkg::ST_IDLE && run_cmd_i && !coast_stop_command_i
                 && !low_v && !alarm);
      rif.load_f = go_saved ? fsave : start_frequency_setting; // R4 R7 R11
      rif.target = resume_saved ? fsave : fcmd; // R5
      rif.enable = state == pdr_pkg::ST_RUN;
      // Fold-back only useful with the limiter on
      rif.limit = overcurrent_limit_enable && over_current_i; // R5 R6
   end

   // Saved-frequency resume: target stays saved until a new command or a stop
   always_ff @(posedge clk_i)
   begin
      if (rst_i || (state != pdr_pkg::ST_RUN && !go_saved))
         resume_saved <= 1'b0;
      else if (go_saved)
         resume_saved <= 1'b1; // R5
      else if (wr_i && addr_i == pdr_pkg::ADDR_FCMD)
         resume_saved <= 1'b0; // New command takes over
   end

   // Registered outputs
   // Outputs come from flops so the stage never sees a decode glitch
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         gate_en_o <= 1'b0;
         freq_o <= 16'h0000;
         alarm_o <= 1'b0;
         irq_o <= 1'b0;
      end
      else
      begin
         gate_en_o <= state == pdr_pkg::ST_RUN && !low_v; // R1 R2 R3
         freq_o <= rif.freq;
         alarm_o <= alarm;
         irq_o <= |(irq_st & irq_mask);
      end
   end

   // Read data one cycle after strobe
   // Zero outside the answer cycle keeps the bus quiet
   always_ff @(posedge clk_i)
   begin
      if (rst_i || !rd_i)
         rdata_o <= 32'h00000000;
      else
      begin
         unique case (addr_i)
            pdr_pkg::ADDR_CTRL: rdata_o <= {27'h0, overcurrent_limit_enable, 1'b0, restart_mode_select};
            pdr_pkg::ADDR_VTHR: rdata_o <= {16'h0, vthr};
            pdr_pkg::ADDR_FSTART: rdata_o <= {16'h0, start_frequency_setting};
            pdr_pkg::ADDR_FCMD: rdata_o <= {16'h0, fcmd};
            pdr_pkg::ADDR_STAT: rdata_o <= {24'h0, alarm, 4'h0, 3'(state)};
            pdr_pkg::ADDR_IRQ: rdata_o <= {28'h0, irq_st};
            pdr_pkg::ADDR_MASK: rdata_o <= {28'h0, irq_mask};
            pdr_pkg::ADDR_FOUT: rdata_o <= {16'h0, rif.freq};
            pdr_pkg::ADDR_FSAVE: rdata_o <= {16'h0, fsave};
            default: rdata_o <= 32'h00000000; // Unmapped reads zero
         endcase
      end
   end
endmodule : pdr_ctrl

// File: inc/pdr_pkg.sv
// Package: constants and types for the power dip restart controller
package pdr_pkg;
   // Restart mode codes
   localparam logic [2:0] MODE_TRIP_NOW = 3'h0;
   localparam logic [2:0] MODE_TRIP_REC = 3'h1;
   localparam logic [2:0] MODE_SAVED_F = 3'h4;
   localparam logic [2:0] MODE_START_F = 3'h5;
   // Register offsets
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_VTHR = 4'h1;
   localparam logic [3:0] ADDR_FSTART = 4'h2;
   localparam logic [3:0] ADDR_FCMD = 4'h3;
   localparam logic [3:0] ADDR_STAT = 4'h4;
   localparam logic [3:0] ADDR_IRQ = 4'h5;
   localparam logic [3:0] ADDR_MASK = 4'h6;
   localparam logic [3:0] ADDR_FOUT = 4'h7;
   localparam logic [3:0] ADDR_FSAVE = 4'h8;
   // Control fields
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_OCL_BIT = 4;
   localparam int CTRL_ARST_BIT = 8;
   // Interrupt bit positions
   localparam int IRQ_FAIL = 0;
   localparam int IRQ_REC = 1;
   localparam int IRQ_ALARM = 2;
   localparam int IRQ_RESTART = 3;
   localparam int IRQ_W = 4;
   // Reset values
   localparam logic [15:0] VTHR_RST = 16'h0000;
   localparam logic [15:0] FSTART_RST = 16'h0000;
   // Timing
   localparam int CLK_HZ = 50000000;
   localparam int HOLD_MS = 500;
   localparam int WAIT_MS = 2000;
   localparam int HOLD_CYC = HOLD_MS * (CLK_HZ / 1000);
   localparam int WAIT_CYC = WAIT_MS * (CLK_HZ / 1000);
   // Sequencer states
   typedef enum logic [2:0] {ST_IDLE, ST_RUN, ST_HOLD, ST_DOWN, ST_WAIT, ST_ALARM} pdr_state_t;
endpackage : pdr_pkg

// File: inc/pdr_ramp_if.sv
// Interface: ramp generator controls
`timescale 1ns/10ps
interface pdr_ramp_if;
   logic load;         // Load frequency
   logic [15:0] load_f; // Load value
   logic [15:0] target; // Ramp target
   logic enable;       // Ramp runs
   logic limit;        // Current limit active
   logic [15:0] freq;  // Present frequency
   modport ctl (output load, load_f, target, enable, limit, input freq);
   modport rmp (input load, load_f, target, enable, limit, output freq);
endinterface : pdr_ramp_if

// File: src/pdr_ramp.sv
// Module: output frequency ramp with current limit fold-back
`timescale 1ns/10ps
module pdr_ramp #(
   parameter int STEP_DIV = 1000 // Clocks per frequency step
) (
   input wire logic clk_i,   // Clock
   input wire logic rst_i,   // Sync reset
   pdr_ramp_if.rmp r         // Controls
);
   logic [15:0] freq;         // Present frequency
   logic [31:0] pre;          // Step prescaler
   assign r.freq = freq;
   // Prescaler for ramp step
   always_ff @(posedge clk_i)
      if (rst_i || pre == 32'(STEP_DIV - 1))
         pre <= '0;
      else
         pre <= pre + 32'h1;
   // Frequency update: load, zero when disabled, fall under limit, or step toward target
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         freq <= 16'h0000;
      else if (r.load)
         freq <= r.load_f;
      else if (!r.enable)
         freq <= 16'h0000;
      else if (pre == 32'(STEP_DIV - 1))
      begin
         if (r.limit && freq != 16'h0000)
            freq <= freq - 16'h1; // R5
         else if (!r.limit && freq < r.target)
            freq <= freq + 16'h1; // R5
         else if (!r.limit && freq > r.target)
            freq <= freq - 16'h1;
      end
   end
endmodule : pdr_ramp

// File: verif/pdr_ctrl_assertions.sv
// Checker: port-level properties of the restart sequencer
`timescale 1ns/10ps
module pdr_ctrl_chk #(
   parameter int HOLD_CYCLES = pdr_pkg::HOLD_CYC // Restart hold-off
) (
   input wire logic clk_i, // Clock
   input wire logic rst_i, // Sync reset
   input wire logic [3:0] addr_i, // Address
   input wire logic [31:0] wdata_i, // Write data
   input wire logic wr_i, // Write strobe
   input wire logic rd_i, // Read strobe
   input wire logic [31:0] rdata_o, // Read data
   input wire logic [15:0] vdc_i, // Link voltage
   input wire logic run_cmd_i, // Run command
   input wire logic coast_stop_command_i, // Coast
   input wire logic gate_en_o, // Stage enable
   input wire logic [15:0] freq_o, // Frequency
   input wire logic alarm_o // Alarm
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [2:0] mode; // Shadow of restart mode
   logic [15:0] vthr; // Shadow of threshold
   logic pend; // Failure awaiting restart
   logic [31:0] cnt; // Cycles since failure
   logic low; // Failure seen while running
   logic clr; // Alarm reset write
   assign low = gate_en_o && (vdc_i < vthr);
   assign clr = wr_i && (addr_i == pdr_pkg::ADDR_CTRL) && wdata_i[pdr_pkg::CTRL_ARST_BIT];
   // Mirror configuration writes
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         mode <= 3'h0;
         vthr <= 16'h0000;
      end
      else if (wr_i && addr_i == pdr_pkg::ADDR_CTRL)
         mode <= wdata_i[pdr_pkg::CTRL_MODE_LSB +: 3];
      else if (wr_i && addr_i == pdr_pkg::ADDR_VTHR)
         vthr <= wdata_i[15:0];
   end
   // Failure bookkeeping; coast or alarm ends the wait
   always_ff @(posedge clk_i)
   begin
      if (rst_i || coast_stop_command_i || alarm_o)
         pend <= 1'b0;
      else if (low)
         pend <= 1'b1;
      else if ($rose(gate_en_o))
         pend <= 1'b0;
      if (low)
         cnt <= 32'h0;
      else if (cnt != 32'hFFFFFFFF)
         cnt <= cnt + 32'h1;
   end
   a_read_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
      else $error("read data outside read cycle");
   a_fail_gate_off: assert property (low |=> !gate_en_o)
      else $error("stage left on at low voltage");
   a_trip_now: assert property (low && mode == pdr_pkg::MODE_TRIP_NOW |-> ##[1:3] alarm_o)
      else $error("no alarm on immediate trip");
   a_trip_quiet: assert property ((low && mode == pdr_pkg::MODE_TRIP_REC) ##1 (vdc_i < vthr) [*2] |-> !alarm_o)
      else $error("alarm during outage");
   a_hold_off: assert property ($rose(gate_en_o) && pend |-> cnt >= HOLD_CYCLES)
      else $error("restart too early");
   a_alarm_latch: assert property (alarm_o && !clr && !$past(clr) |=> alarm_o)
      else $error("alarm dropped by itself");
   a_alarm_no_gate: assert property (alarm_o |-> !gate_en_o)
      else $error("stage on during alarm");
   a_start_run: assert property ($rose(gate_en_o) |-> $past(run_cmd_i))
      else $error("start without run command");
   a_freq_slew: assert property (gate_en_o && $past(gate_en_o) |->
      (freq_o - $past(freq_o) + 16'h0001) <= 16'h0002) else $error("frequency jumped");
   c_restart: cover property ($rose(gate_en_o) && pend);
   c_alarm: cover property ($rose(alarm_o));
   c_coast: cover property (coast_stop_command_i && pend);
endmodule : pdr_ctrl_chk
bind pdr_ctrl pdr_ctrl_chk #(.HOLD_CYCLES(HOLD_CYCLES)) i_chk (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
   .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .vdc_i(vdc_i), .run_cmd_i(run_cmd_i),
   .coast_stop_command_i(coast_stop_command_i), .gate_en_o(gate_en_o), .freq_o(freq_o), .alarm_o(alarm_o));

// File: verif/pdr_far_model.sv
// Model: supply, run relay circuitry and coasting motor
`timescale 1ns/10ps
module pdr_far_model (
   input wire logic clk_i, // Clock
   input wire logic rst_i, // Sync reset
   input wire logic supply_ok_i, // Mains present
   input wire logic run_req_i, // Operator run
   input wire logic [7:0] rerun_dly_i, // Relay recovery delay
   input wire logic gate_en_i, // Stage enable
   input wire logic [15:0] freq_i, // Drive frequency
   output logic [15:0] vdc_o, // Link voltage
   output logic run_cmd_o, // Run command
   output logic over_current_o // Current over limit
);
   logic [7:0] up_cnt; // Cycles since supply return
   logic [15:0] speed; // Motor speed
   // Link sags with the supply
   always_ff @(posedge clk_i)
      vdc_o <= supply_ok_i ? 16'h0100 : 16'h0040;
   // Relay drops in an outage, returns after a delay
   always_ff @(posedge clk_i)
   begin
      if (rst_i || !supply_ok_i)
         up_cnt <= 8'h00;
      else if (up_cnt != 8'hFF)
         up_cnt <= up_cnt + 8'h01;
   end
   // Relay supply sags with the link, so the command falls no earlier
   assign run_cmd_o = run_req_i && (vdc_o == 16'h0100) && (up_cnt >= rerun_dly_i);
   // Motor follows the drive, coasts down when released
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         speed <= 16'h0000;
      else if (gate_en_i && speed < freq_i)
         speed <= speed + 16'h0001;
      else if (!gate_en_i && speed != 16'h0000)
         speed <= speed - 16'h0001;
   end
   assign over_current_o = gate_en_i && (freq_i > speed + 16'h0002);
endmodule : pdr_far_model

// File: verif/power_dip_restart_control_test.sv
// Testbench: restart sequencer under supply dips
`timescale 1ns/10ps
module power_dip_restart_control_test;
   localparam int HOLD = 20; // Short hold-off
   localparam logic [15:0] FST = 16'h0010; // Start frequency
   localparam logic [15:0] FCM = 16'h0030; // Command frequency
   logic clk_i = 1'b0; // Clock
   logic rst_i = 1'b1; // Reset
   logic [3:0] addr_i = 4'h0; // Address
   logic [31:0] wdata_i = 32'h0; // Write data
   logic wr_i = 1'b0; // Write strobe
   logic rd_i = 1'b0; // Read strobe
   logic coast_stop_command_i = 1'b0; // Coast
   logic supply_ok = 1'b1; // Mains present
   logic run_req = 1'b0; // Operator run
   logic [7:0] rerun_dly = 8'h02; // Relay delay
   logic [31:0] rdata_o; // Read data
   logic [15:0] vdc_i; // Link voltage
   logic run_cmd_i; // Run command
   logic over_current_i; // Over limit
   logic gate_en_o; // Stage enable
   logic [15:0] freq_o; // Frequency
   logic alarm_o; // Alarm
   logic irq_o; // Interrupt
   logic [15:0] fmin = 16'hFFFF; // Lowest frequency
   logic fmin_clr = 1'b0; // Restart lowest-frequency tracking
   logic [31:0] rd_val; // Last read
   int fail_count = 0; // Mismatches
   int tests_run = 0; // Comparisons
   int cyc = 0; // Cycles run
   pdr_ctrl #(.HOLD_CYCLES(HOLD), .WAIT_CYCLES(50), .STEP_DIV(2)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .vdc_i(vdc_i),
      .run_cmd_i(run_cmd_i), .coast_stop_command_i(coast_stop_command_i), .over_current_i(over_current_i),
      .gate_en_o(gate_en_o), .freq_o(freq_o), .alarm_o(alarm_o), .irq_o(irq_o));
   pdr_far_model i_far (.clk_i(clk_i), .rst_i(rst_i), .supply_ok_i(supply_ok), .run_req_i(run_req),
      .rerun_dly_i(rerun_dly), .gate_en_i(gate_en_o), .freq_i(freq_o), .vdc_o(vdc_i), .run_cmd_o(run_cmd_i),
      .over_current_o(over_current_i));
   always #10 clk_i = ~clk_i;
   // Lowest frequency and hang guard
   always @(posedge clk_i)
   begin
      if (fmin_clr || freq_o < fmin)
         fmin <= freq_o;
      cyc++;
      if (cyc == 20000)
      begin
         fail_count++;
         finish_test();
      end
   end
   task automatic finish_test();
      $display("Counts: %0d checks, %0d mismatches", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : finish_test
   task automatic check_eq(input logic [31:0] got, input logic [31:0] exp, input string what);
      tests_run++;
      if (got !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask : check_eq
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a);
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 rd_val = rdata_o;
   endtask : rd
   task automatic wait_gate(input logic lvl, output int n);
      n = 0;
      while (gate_en_o !== lvl && n < 3000)
      begin
         @(posedge clk_i);
         #1 n++;
      end
   endtask : wait_gate
   task automatic wait_freq();
      int n;
      n = 0;
      while (freq_o !== FCM && n < 3000)
      begin
         @(posedge clk_i);
         #1 n++;
      end
   endtask : wait_freq
   // Configure mode with limiter on, run up to speed
   task automatic start(input logic [2:0] m);
      int n;
      wr(pdr_pkg::ADDR_CTRL, {27'h0, 1'b1, 1'b0, m});
      @(posedge clk_i);
      run_req <= 1'b1;
      wait_gate(1'b1, n);
      wait_freq();
   endtask : start
   task automatic dip(input int len);
      @(posedge clk_i);
      supply_ok <= 1'b0;
      repeat (len) @(posedge clk_i);
      supply_ok <= 1'b1;
   endtask : dip
   // Alarm reset, then interrupt status clear
   task automatic clear_alarm();
      @(posedge clk_i);
      run_req <= 1'b0;
      wr(pdr_pkg::ADDR_CTRL, 32'h100);
      repeat (2) @(posedge clk_i);
      #1 check_eq(alarm_o, 1'b0, "alarm reset");
      wr(pdr_pkg::ADDR_IRQ, 32'hF);
      repeat (2) @(posedge clk_i);
      #1 check_eq(irq_o, 1'b0, "irq clear");
   endtask : clear_alarm
   // Dip, optional coast, check restart frequency and timing
   task automatic dip_restart(input logic [2:0] m, input logic [7:0] d, input logic cst, input logic [15:0] ef);
      int n;
      wr(pdr_pkg::ADDR_IRQ, 32'hF);
      start(m);
      rerun_dly <= d;
      dip(5);
      coast_stop_command_i <= cst;
      @(posedge clk_i);
      coast_stop_command_i <= 1'b0;
      #1 wait_gate(1'b1, n);
      check_eq(cst || n + 6 >= HOLD, 1'b1, "hold-off");
      check_eq(freq_o - ef <= 16'h0001, 1'b1, "restart frequency");
      fmin_clr <= 1'b1;
      @(posedge clk_i);
      fmin_clr <= 1'b0;
      repeat (19) @(posedge clk_i);
      wait_freq();
      check_eq(ef != FCM || fmin < FCM, 1'b1, "limiter dip");
      check_eq(freq_o, FCM, "back at command");
      rd(pdr_pkg::ADDR_IRQ);
      check_eq(rd_val, cst ? 32'h1 : 32'hB, "restart events");
      @(posedge clk_i);
      run_req <= 1'b0;
      wait_gate(1'b0, n);
      repeat (60) @(posedge clk_i);
      $display("restart test mode %0d done", m);
   endtask : dip_restart
   initial
   begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int a = 0; a < 16; a++)
      begin
         rd(4'(a));
         check_eq(rd_val, 32'h0, "reset value");
      end
      wr(pdr_pkg::ADDR_FOUT, 32'hFFFF);
      wr(4'hF, 32'hFFFF);
      rd(pdr_pkg::ADDR_FOUT);
      check_eq(rd_val, 32'h0, "read-only");
      rd(4'hF);
      check_eq(rd_val, 32'h0, "unmapped");
      wr(pdr_pkg::ADDR_VTHR, 32'h80);
      wr(pdr_pkg::ADDR_FSTART, {16'h0, FST});
      wr(pdr_pkg::ADDR_FCMD, {16'h0, FCM});
      wr(pdr_pkg::ADDR_MASK, 32'hF);
      rd(pdr_pkg::ADDR_VTHR);
      check_eq(rd_val, 32'h80, "threshold");
      $display("register test done");
      start(pdr_pkg::MODE_TRIP_NOW);
      dip(5);
      repeat (100) @(posedge clk_i);
      #1 check_eq({gate_en_o, alarm_o, irq_o}, 3'b011, "trip now");
      rd(pdr_pkg::ADDR_STAT);
      check_eq(rd_val, 32'h85, "alarm state");
      rd(pdr_pkg::ADDR_IRQ);
      check_eq(rd_val & 32'h5, 32'h5, "fail and alarm events");
      wr(pdr_pkg::ADDR_MASK, 32'h0);
      repeat (2) @(posedge clk_i);
      #1 check_eq(irq_o, 1'b0, "irq masked");
      wr(pdr_pkg::ADDR_MASK, 32'hF);
      clear_alarm();
      $display("trip test done");
      start(pdr_pkg::MODE_TRIP_REC);
      @(posedge clk_i);
      supply_ok <= 1'b0;
      repeat (8) @(posedge clk_i);
      #1 check_eq({gate_en_o, alarm_o}, 2'b00, "quiet outage");
      @(posedge clk_i);
      supply_ok <= 1'b1;
      repeat (6) @(posedge clk_i);
      #1 check_eq(alarm_o, 1'b1, "alarm on recovery");
      rd(pdr_pkg::ADDR_IRQ);
      check_eq(rd_val, 32'h7, "recovery events");
      clear_alarm();
      $display("trip after recovery test done");
      start(3'h2);
      dip(5);
      repeat (20) @(posedge clk_i);
      #1 check_eq({gate_en_o, alarm_o}, 2'b01, "unsupported mode trips");
      clear_alarm();
      $display("unsupported mode test done");
      dip_restart(pdr_pkg::MODE_SAVED_F, 8'h02, 1'b0, FCM);
      rd(pdr_pkg::ADDR_FSAVE);
      check_eq(rd_val, {16'h0, FCM}, "saved frequency");
      dip_restart(pdr_pkg::MODE_SAVED_F, 8'd100, 1'b0, FST);
      dip_restart(pdr_pkg::MODE_START_F, 8'h02, 1'b0, FST);
      dip_restart(pdr_pkg::MODE_SAVED_F, 8'h02, 1'b1, FST);
      finish_test();
   end
endmodule : power_dip_restart_control_test
